// ==== echo_datapath_output_control.sv ====
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Contract
// (R1) Echo sample register refreshes once per decimated output period.
// (R2) Each result is also written to sample memory in the selected format.
// (R3) Format 00 stores all 12 bits using two bytes.
// (R4) Format 01 stores the upper eight result bits.
// (R5) Format 10 stores low eight bits, or 0xFF if top four bits nonzero.
// (R6) Format 11 stores bits 10..3, or 0xFF if top two bits nonzero.
// (R7) Run bit low: no computation and no sample memory writes.
// (R8) Run bit low: band-pass and low-pass filter state held at zero.
// (R9) Run bit high: compute at once, suppress memory writes until hold-off ends.
// (R10) Hold-off setting is eight bits of 16 us steps, up to 4.08 ms.
// (R11) Monitor converter is driven from datapath output; meaningful in 8-bit formats.
// (R12) Selected 8-bit value is the converter code with no scaling.
// (R13) Route select decides if converter reaches the monitor pin; none after reset.
// (R14) Thermal reading register frozen while the converter carries datapath output.
// (R15) Software enables the monitor converter before expecting any converter output.
// (R16) Source select assigns the converter to temperature or datapath output.
// (R17) Converter gets the 8-bit value, or upper eight bits in 12-bit format.
// (R18) Last-write index advances by two in 12-bit format, by one otherwise.
// (R19) Index clears at reset and when run is set; memory contents kept.
// (R20) Hold-off starts on run rising, aborts on run clear, restarts fully.
module echo_datapath_output_control #(
  parameter int MEM_DEPTH = 768,
  parameter int MEM_ADDR_W = 10
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Converter samples in.
  input wire logic [11:0] adcSample,
  input wire logic adcValid,
  // Temperature code in.
  input wire logic [7:0] thermalCode,
  input wire logic thermalValid,
  // Sample memory write port.
  output logic memWrEn,
  output logic [MEM_ADDR_W-1:0] memAddr,
  output logic [7:0] memWrData,
  // Monitor converter.
  output logic [7:0] dacCode,
  output logic monitorConverterEnable,
  output logic monitorSourceSelect,
  output logic analogRouteSelect
);

  if (MEM_DEPTH < 4 || MEM_DEPTH > (1 << MEM_ADDR_W)) begin : g_check
    $error("MEM_DEPTH does not fit MEM_ADDR_W");
  end

  logic [5:0] ctrl_reg;
  logic [7:0] decimationRatio_reg;
  logic [7:0] holdoff_reg;
  logic [11:0] echoSample_reg;
  logic [MEM_ADDR_W-1:0] index_reg;
  logic [7:0] thermalReading_reg;
  logic [31:0] prdata_reg;
  logic runPrev_reg;
  echo_out_pkg::run_e state_reg;
  echo_out_pkg::run_e state_next;
  logic [8:0] prescale_reg;
  logic [7:0] holdCount_reg;
  logic [7:0] decimCount_reg;
  logic [11:0] prevSample_reg;
  logic [13:0] lpAcc_reg;
  logic pendingHigh_reg;
  logic [3:0] highNibble_reg;
  logic memWrEn_reg;
  logic [MEM_ADDR_W-1:0] memAddr_reg;
  logic [7:0] memWrData_reg;
  logic [7:0] dacCode_reg;

  // Register decode.
  wire run = ctrl_reg[echo_out_pkg::CTRL_RUN];
  wire echo_out_pkg::fmt_e fmt = echo_out_pkg::fmt_e'(ctrl_reg[echo_out_pkg::CTRL_FMT_LO +: 2]);
  wire monEn = ctrl_reg[echo_out_pkg::CTRL_MON_EN];
  wire monSrc = ctrl_reg[echo_out_pkg::CTRL_MON_SRC];
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hitCtrl = paddr == echo_out_pkg::ADDR_CTRL;
  wire hitDecim = paddr == echo_out_pkg::ADDR_DECIM;
  wire hitHold = paddr == echo_out_pkg::ADDR_HOLDOFF;
  wire hitEcho = paddr == echo_out_pkg::ADDR_ECHO;
  wire hitIndex = paddr == echo_out_pkg::ADDR_INDEX;
  wire hitTherm = paddr == echo_out_pkg::ADDR_THERMAL;
  wire hitStat = paddr == echo_out_pkg::ADDR_STATUS;
  wire hitAny = hitCtrl || hitDecim || hitHold || hitEcho || hitIndex || hitTherm || hitStat;
  wire writeOk = access && pwrite && hitAny;
  wire [31:0] readMux =
    hitCtrl ? {26'h000_0000, ctrl_reg} :
    hitDecim ? {24'h00_0000, decimationRatio_reg} :
    hitHold ? {24'h00_0000, holdoff_reg} :
    hitEcho ? {20'h0_0000, echoSample_reg} :
    hitIndex ? {{(32 - MEM_ADDR_W){1'b0}}, index_reg} :
    hitTherm ? {24'h00_0000, thermalReading_reg} :
    hitStat ? {29'h0000_0000, pendingHigh_reg, state_reg} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access && !hitAny;
  assign prdata = prdata_reg;

  // Datapath: rectified difference as band-pass, one-pole low-pass after it.
  wire runRise = run && !runPrev_reg;
  wire [11:0] bpOut = (adcSample >= prevSample_reg) ? adcSample - prevSample_reg : prevSample_reg - adcSample;
  wire [14:0] lpSum = {1'b0, lpAcc_reg} + {3'b000, bpOut} - {3'b000, lpAcc_reg[13:2]};
  wire [13:0] lpAccNext = lpSum[13:0];
  wire [11:0] result = lpAccNext[13:2];
  wire [7:0] ratioEff = (decimationRatio_reg < 8'h02) ? 8'h02 : decimationRatio_reg;
  // (R1) decimated output tick
  wire tick = run && adcValid && (decimCount_reg == ratioEff - 8'h01);
  wire storeNow = tick && (state_reg == echo_out_pkg::ST_RUN);

  // (R4) (R5) (R6) byte packing
  wire [7:0] packedByte =
    (fmt == echo_out_pkg::FMT_UPPER) ? result[11:4] :
    (fmt == echo_out_pkg::FMT_LOWER) ? ((result[11:8] == 4'h0) ? result[7:0] : echo_out_pkg::SAT_BYTE) :
    ((result[11:10] == 2'b00) ? result[10:3] : echo_out_pkg::SAT_BYTE);

  // Sample memory addressing wraps at MEM_DEPTH.
  localparam logic [MEM_ADDR_W:0] DEPTH_W = (MEM_ADDR_W + 1)'(MEM_DEPTH);
  wire [MEM_ADDR_W:0] sum1 = {1'b0, index_reg} + (MEM_ADDR_W + 1)'(1);
  wire [MEM_ADDR_W:0] sum2 = {1'b0, index_reg} + (MEM_ADDR_W + 1)'(2);
  wire [MEM_ADDR_W-1:0] addr1 = (sum1 >= DEPTH_W) ? MEM_ADDR_W'(sum1 - DEPTH_W) : sum1[MEM_ADDR_W-1:0];
  wire [MEM_ADDR_W-1:0] addr2 = (sum2 >= DEPTH_W) ? MEM_ADDR_W'(sum2 - DEPTH_W) : sum2[MEM_ADDR_W-1:0];

  // (R9) (R20) hold-off sequencing
  wire holdDone = (prescale_reg == echo_out_pkg::PRESCALE_LAST) && (holdCount_reg == 8'h01);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      echo_out_pkg::ST_IDLE: begin
        if (runRise) begin
          state_next = (holdoff_reg == 8'h00) ? echo_out_pkg::ST_RUN : echo_out_pkg::ST_BLANK;
        end
      end
      echo_out_pkg::ST_BLANK: begin
        if (!run) begin
          state_next = echo_out_pkg::ST_IDLE;
        end else if (holdDone) begin
          state_next = echo_out_pkg::ST_RUN;
        end
      end
      echo_out_pkg::ST_RUN: begin
        if (!run) begin
          state_next = echo_out_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = echo_out_pkg::ST_IDLE;
      end
    endcase
  end

  // Register file.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= echo_out_pkg::CTRL_RESET;
      decimationRatio_reg <= echo_out_pkg::DECIM_RESET;
      holdoff_reg <= echo_out_pkg::HOLDOFF_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (writeOk && hitCtrl) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (writeOk && hitDecim) begin
        decimationRatio_reg <= pwdata[7:0];
      end
      // (R10) 8-bit hold-off setting
      if (writeOk && hitHold) begin
        holdoff_reg <= pwdata[7:0];
      end
      if (setup && !pwrite) begin
        prdata_reg <= readMux;
      end
    end
  end

  // Hold-off timer and run state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      runPrev_reg <= 1'b0;
      state_reg <= echo_out_pkg::ST_IDLE;
      prescale_reg <= 9'h000;
      holdCount_reg <= 8'h00;
    end else begin
      runPrev_reg <= run;
      state_reg <= state_next;
      // (R10) 16 us step count
      if (runRise) begin
        prescale_reg <= 9'h000;
        holdCount_reg <= holdoff_reg;
      end else if (state_reg == echo_out_pkg::ST_BLANK) begin
        if (prescale_reg == echo_out_pkg::PRESCALE_LAST) begin
          prescale_reg <= 9'h000;
          holdCount_reg <= holdCount_reg - 8'h01;
        end else begin
          prescale_reg <= prescale_reg + 9'h001;
        end
      end
    end
  end

  // Filters and decimation.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prevSample_reg <= 12'h000;
      lpAcc_reg <= 14'h0000;
      decimCount_reg <= 8'h00;
      echoSample_reg <= 12'h000;
    end else if (!run) begin
      // (R7) (R8) filters cleared while stopped
      prevSample_reg <= 12'h000;
      lpAcc_reg <= 14'h0000;
      decimCount_reg <= 8'h00;
    end else if (adcValid) begin
      prevSample_reg <= adcSample;
      lpAcc_reg <= lpAccNext;
      decimCount_reg <= tick ? 8'h00 : decimCount_reg + 8'h01;
      // (R1) echo sample refresh
      if (tick) begin
        echoSample_reg <= result;
      end
    end
  end

  // Sample memory writes and last-write index.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      index_reg <= '0;
      memWrEn_reg <= 1'b0;
      memAddr_reg <= '0;
      memWrData_reg <= 8'h00;
      pendingHigh_reg <= 1'b0;
      highNibble_reg <= 4'h0;
    end else begin
      memWrEn_reg <= 1'b0;
      pendingHigh_reg <= 1'b0;
      // (R19) index clear on run set
      if (runRise) begin
        index_reg <= '0;
      end else if (pendingHigh_reg && run) begin
        // (R3) second byte of a 12-bit result
        memWrEn_reg <= 1'b1;
        memAddr_reg <= addr2;
        memWrData_reg <= {4'h0, highNibble_reg};
        index_reg <= addr2;
      end else if (storeNow) begin
        // (R2) (R18) store first byte
        memWrEn_reg <= 1'b1;
        memAddr_reg <= addr1;
        if (fmt == echo_out_pkg::FMT_FULL) begin
          memWrData_reg <= result[7:0];
          highNibble_reg <= result[11:8];
          pendingHigh_reg <= 1'b1;
        end else begin
          memWrData_reg <= packedByte;
          index_reg <= addr1;
        end
      end
    end
  end

  assign memWrEn = memWrEn_reg;
  assign memAddr = memAddr_reg;
  assign memWrData = memWrData_reg;

  // Monitor converter and thermal reading.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dacCode_reg <= 8'h00;
      thermalReading_reg <= 8'h00;
    end else begin
      // (R11) (R12) (R17) converter code
      if (tick) begin
        dacCode_reg <= (fmt == echo_out_pkg::FMT_FULL) ? result[11:4] : packedByte;
      end
      // (R14) (R16) thermal freeze
      if (thermalValid && monEn && !monSrc) begin
        thermalReading_reg <= thermalCode;
      end
    end
  end

  assign dacCode = dacCode_reg;
  // (R13) (R15) (R16) enables and route
  assign monitorConverterEnable = monEn;
  assign monitorSourceSelect = monSrc;
  assign analogRouteSelect = ctrl_reg[echo_out_pkg::CTRL_ROUTE];

  property p_echo_refresh;
    @(posedge clk_sys) disable iff (!reset_n) tick |=> echoSample_reg == $past(result);
  endproperty
  a_echo_refresh: assert property (p_echo_refresh) else $error("echo sample not refreshed"); // (R1)

  property p_full_pair;
    @(posedge clk_sys) disable iff (!reset_n)
      (storeNow && fmt == echo_out_pkg::FMT_FULL && !pendingHigh_reg && !runRise) ##1 run
      |-> memWrEn && memWrData == $past(result[7:0]) ##1 memWrEn && memWrData[7:4] == 4'h0;
  endproperty
  a_full_pair: assert property (p_full_pair) else $error("12-bit pair not written"); // (R3)

  property p_lower_sat;
    @(posedge clk_sys) disable iff (!reset_n)
      (storeNow && fmt == echo_out_pkg::FMT_LOWER && result[11:8] != 4'h0 && !pendingHigh_reg && !runRise)
      |=> memWrEn && memWrData == 8'hFF;
  endproperty
  a_lower_sat: assert property (p_lower_sat) else $error("low format not saturated"); // (R5)

  property p_stopped_no_write;
    @(posedge clk_sys) disable iff (!reset_n) memWrEn |-> $past(run);
  endproperty
  a_stopped_no_write: assert property (p_stopped_no_write) else $error("write while stopped"); // (R7)

  property p_filter_clear;
    @(posedge clk_sys) disable iff (!reset_n) !run |=> lpAcc_reg == 14'h0000 && prevSample_reg == 12'h000;
  endproperty
  a_filter_clear: assert property (p_filter_clear) else $error("filter state not cleared"); // (R8)

  property p_blank_no_write;
    @(posedge clk_sys) disable iff (!reset_n) (state_reg != echo_out_pkg::ST_RUN && !pendingHigh_reg) |=> !memWrEn;
  endproperty
  a_blank_no_write: assert property (p_blank_no_write) else $error("write during hold-off"); // (R9)

  // Cycles spent in hold-off, kept apart from the prescaler so the length check is independent.
  logic [16:0] blankAge_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blankAge_reg <= 17'h0_0000;
    end else begin
      blankAge_reg <= (state_reg == echo_out_pkg::ST_BLANK) ? blankAge_reg + 17'h0_0001 : 17'h0_0000;
    end
  end

  property p_holdoff_one;
    @(posedge clk_sys) disable iff (!reset_n)
      state_reg == echo_out_pkg::ST_BLANK ##1 state_reg == echo_out_pkg::ST_RUN
      |-> blankAge_reg == 17'(holdoff_reg) * 17'(echo_out_pkg::HOLD_STEP_CYCLES);
  endproperty
  a_holdoff_one: assert property (p_holdoff_one) else $error("hold-off length wrong"); // (R10)

  property p_thermal_hold;
    @(posedge clk_sys) disable iff (!reset_n) (monEn && monSrc) |=> $stable(thermalReading_reg);
  endproperty
  a_thermal_hold: assert property (p_thermal_hold) else $error("thermal reading changed"); // (R14)

  property p_index_clear;
    @(posedge clk_sys) disable iff (!reset_n) runRise |=> index_reg == '0;
  endproperty
  a_index_clear: assert property (p_index_clear) else $error("index not cleared"); // (R19)

  property p_abort;
    @(posedge clk_sys) disable iff (!reset_n) !run |=> state_reg == echo_out_pkg::ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("hold-off not aborted"); // (R20)

endmodule

// ==== echo_datapath_output_control_tb.sv ====
`timescale 1ns/1ps
module echo_datapath_output_control_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [11:0] adcSample = 12'h000;
  logic adcValid = 1'b0;
  logic [7:0] thermalCode = 8'h00;
  logic thermalValid = 1'b0;
  logic memWrEn;
  logic [9:0] memAddr;
  logic [7:0] memWrData;
  logic [7:0] dacCode;
  logic monEn, monSrc, routeSel, slvErr;
  logic [31:0] rd;
  logic [11:0] prevX, res;
  logic [13:0] acc, bp;
  logic [9:0] expIdx;
  logic [1:0] fmt;
  int writeCount, cnt, ratio, wc;
  int err_total = 0;
  int cmp_count = 0;
  bit runOn, store;

  always #25 clk_sys = ~clk_sys;

  echo_datapath_output_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .adcSample(adcSample), .adcValid(adcValid), .thermalCode(thermalCode),
    .thermalValid(thermalValid), .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
    .dacCode(dacCode), .monitorConverterEnable(monEn), .monitorSourceSelect(monSrc),
    .analogRouteSelect(routeSel));

  sample_mem_model mem (.clk_sys(clk_sys), .memWrEn(memWrEn), .memAddr(memAddr),
    .memWrData(memWrData), .writeCount(writeCount));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic readReg(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [31:0] ctl(input logic run, input logic [1:0] f, input logic src);
    return {26'h000_0000, 1'b1, src, 1'b1, f, run};
  endfunction

  function automatic logic [7:0] byteFor(input logic [1:0] f, input logic [11:0] r);
    case (f)
      2'b10: return (r[11:8] != 4'h0) ? echo_out_pkg::SAT_BYTE : r[7:0];
      2'b11: return (r[11:10] != 2'b00) ? echo_out_pkg::SAT_BYTE : r[10:3];
      default: return r[11:4];
    endcase
  endfunction

  task automatic restart();
    prevX = 12'h000;
    acc = 14'h0000;
    cnt = 0;
    expIdx = 10'h000;
  endtask

  task automatic send(input logic [11:0] x, input bit chk);
    bit tick = 1'b0;
    @(posedge clk_sys);
    adcSample <= x;
    adcValid <= 1'b1;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    if (runOn) begin
      bp = (x > prevX) ? 14'(x - prevX) : 14'(prevX - x);
      acc = acc + bp - (acc >> 2);
      prevX = x;
      cnt++;
      if (cnt == ratio) begin
        cnt = 0;
        tick = 1'b1;
        res = acc[13:2];
      end
    end
    @(posedge clk_sys);
    if (tick && chk) check(dacCode, byteFor(fmt, res)); // converter code
    repeat (3) @(posedge clk_sys);
    if (tick && chk && store) begin
      if (fmt == 2'b00) begin
        expIdx = expIdx + 10'h002;
        check(mem.bytes[expIdx - 1], res[7:0]); // low byte first
        check(mem.bytes[expIdx], {4'h0, res[11:8]}); // high byte second
      end else begin
        expIdx = expIdx + 10'h001;
        check(mem.bytes[expIdx], byteFor(fmt, res)); // selected byte
      end
    end
  endtask

  task automatic pulseThermal(input logic [7:0] c);
    @(posedge clk_sys);
    thermalCode <= c;
    thermalValid <= 1'b1;
    @(posedge clk_sys);
    thermalValid <= 1'b0;
  endtask

  initial begin
    restart();
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    check(routeSel, 1'b0); // nothing routed
    readReg(echo_out_pkg::ADDR_DECIM);
    check(rd, 32'h0000_0002); // default ratio
    readReg(echo_out_pkg::ADDR_INDEX);
    check(rd, 32'h0000_0000); // index at power-up
    readReg(8'h1C);
    check(slvErr, 1'b1);
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b0, 2'b01, 1'b1));
    pulseThermal(8'h5A);
    readReg(echo_out_pkg::ADDR_THERMAL);
    check(rd, 32'h0000_0000); // reading frozen
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b0, 2'b01, 1'b0));
    pulseThermal(8'h3C);
    readReg(echo_out_pkg::ADDR_THERMAL);
    check(rd, 32'h0000_003C); // temperature source
    check({monEn, monSrc, routeSel}, 3'b101); // control outputs
    ratio = 3;
    apb(1'b1, echo_out_pkg::ADDR_DECIM, 32'h0000_0003);
    for (int f = 0; f < 4; f++) begin
      fmt = 2'(f);
      apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b0, fmt, 1'b1));
      runOn = 1'b0;
      restart();
      apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b1, fmt, 1'b1));
      runOn = 1'b1;
      store = 1'b1;
      readReg(echo_out_pkg::ADDR_INDEX);
      check(rd, 32'h0000_0000); // index cleared on run
      for (int i = 0; i < 12; i++) send(i < 6 ? 12'(i * 37) : (i % 2 ? 12'hFFF : 12'h000), 1'b1);
      readReg(echo_out_pkg::ADDR_INDEX);
      check(rd, 32'(expIdx)); // index step
      readReg(echo_out_pkg::ADDR_ECHO);
      check(rd, 32'(res)); // echo result
    end
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b0, fmt, 1'b1));
    runOn = 1'b0;
    wc = writeCount;
    for (int i = 0; i < 6; i++) send(12'hFFF, 1'b0);
    check(writeCount, wc); // no writes while stopped
    apb(1'b1, echo_out_pkg::ADDR_HOLDOFF, 32'h0000_0001);
    fmt = 2'b01;
    restart();
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b1, fmt, 1'b1));
    runOn = 1'b1;
    store = 1'b0;
    for (int i = 0; i < 30; i++) send(i % 2 ? 12'hFFF : 12'h000, 1'b1);
    readReg(echo_out_pkg::ADDR_STATUS);
    check(rd[1:0], 2'h1); // hold-off state
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b0, fmt, 1'b1));
    restart();
    apb(1'b1, echo_out_pkg::ADDR_CTRL, ctl(1'b1, fmt, 1'b1));
    for (int i = 0; i < 40; i++) send(i % 2 ? 12'hFFF : 12'h000, 1'b1);
    check(writeCount, wc); // restarted hold-off
    for (int i = 0; i < 20; i++) send(i % 2 ? 12'hFFF : 12'h000, 1'b0);
    readReg(echo_out_pkg::ADDR_STATUS);
    check(rd[1:0], 2'h2); // hold-off expired
    check(writeCount > wc, 1'b1); // storing resumes
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end
endmodule

// ==== echo_out_pkg.sv ====
package echo_out_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DECIM = 8'h04;
  localparam logic [7:0] ADDR_HOLDOFF = 8'h08;
  localparam logic [7:0] ADDR_ECHO = 8'h0C;
  localparam logic [7:0] ADDR_INDEX = 8'h10;
  localparam logic [7:0] ADDR_THERMAL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Control register field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FMT_LO = 1;
  localparam int CTRL_MON_EN = 3;
  localparam int CTRL_MON_SRC = 4;
  localparam int CTRL_ROUTE = 5;
  localparam int CTRL_W = 6;
  // Reset values and the saturation byte.
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] DECIM_RESET = 8'h02;
  localparam logic [7:0] HOLDOFF_RESET = 8'h00;
  localparam logic [7:0] SAT_BYTE = 8'hFF;
  // Sample store formats.
  typedef enum logic [1:0] {
    FMT_FULL = 2'b00,
    FMT_UPPER = 2'b01,
    FMT_LOWER = 2'b10,
    FMT_MIDDLE = 2'b11
  } fmt_e;
  // Datapath run states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BLANK = 2'b01,
    ST_RUN = 2'b10
  } run_e;
  // Timing.
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_STEP_NS = 16_000;
  localparam int HOLD_STEP_CYCLES = (HOLD_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PRESCALE_W = 9;
  localparam logic [8:0] PRESCALE_LAST = 9'(HOLD_STEP_CYCLES - 1);
endpackage

// ==== sample_mem_model.sv ====
`timescale 1ns/1ps
module sample_mem_model #(
  parameter int DEPTH = 768,
  parameter int AW = 10
) (
  // Write port from the datapath.
  input wire logic clk_sys,
  input wire logic memWrEn,
  input wire logic [AW-1:0] memAddr,
  input wire logic [7:0] memWrData,
  // Bytes stored so far.
  output int writeCount
);
  logic [7:0] bytes [DEPTH];
  initial begin
    writeCount = 0;
    foreach (bytes[i]) bytes[i] = 8'hA5;
  end
  always @(posedge clk_sys) begin
    if (memWrEn) begin
      bytes[memAddr] <= memWrData;
      writeCount <= writeCount + 1;
    end
  end
endmodule
